//--- afd_anc_packet_inserter_tb.sv
`timescale 1ns/100ps
`default_nettype none
module afd_anc_packet_inserter_tb import afd_pkg::*; ;
	logic clk, rst_b, reg_wr, reg_rd, vs, ins, live, rd_d, ins_d;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, b1, b2;
	logic [10:0] ln, fl, ll;
	logic [11:0] sn, aw;
	logic [9:0] li, ci, lo, co, li_d, ci_d, w, m_did, m_sdid, m_cs;
	logic [9:0] m_udw [8];
	logic [3:0] m_dc;
	logic m_par, m_csm, m_chr;
	logic [9:0] pq [$];
	logic [31:0] rq [$];
	logic [31:0] e;
	logic [15:0] rv [8] = '{16'h0, 16'h41, 16'h5, 16'h8, 16'h0, 16'h9, 16'h0, 16'h0};
	int failures, total_checks, pkts;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	afd_video_src src (.clk(clk), .rst_b(rst_b), .line_num(ln), .sample_num(sn), .vertical_ancillary_space(vs),
		.first_line(fl), .last_line(ll), .width(aw), .luma(li), .chroma(ci));
	afd_inserter dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_num(ln), .sample_num(sn),
		.in_vertical_ancillary_space(vs), .vertical_ancillary_space_first_line(fl), .vertical_ancillary_space_last_line(ll),
		.active_width(aw), .luma_in(li), .chroma_in(ci), .luma_out(lo), .chroma_out(co),
		.inserting(ins));
	task end_of_test();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task check(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
		total_checks++;
		if ((got & m) !== (exp & m)) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
		if (a == 4'h0) {m_chr, m_csm, m_par} = d[4:2];
		if (a == 4'h1) m_did = d[9:0];
		if (a == 4'h2) m_sdid = d[9:0];
		if (a == 4'h3) m_dc = (d > 16'h8) ? 4'h8 : d[3:0];
		if (a == 4'h4) m_cs = d[9:0];
		if (a >= 4'h8) m_udw[a[2:0]] = d[9:0];
	endtask
	task rd(input logic [3:0] a, input logic [15:0] x, input logic [15:0] m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back({m, x});
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	// Frame start is a safe moment to reconfigure, before the first ancillary line
	task wait_frame();
		int n;
		n = 0;
		@(posedge clk);
		while ((ln !== 11'h001 || sn !== 12'h000) && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000) begin
			failures++;
			end_of_test();
		end
	endtask
	function automatic logic [9:0] fw(input logic [9:0] v);
		return m_par ? v : {~(^v[7:0]), ^v[7:0], v[7:0]};
	endfunction
	task exp_pkt();
		logic [8:0] s;
		logic [9:0] x;
		s = 9'h000;
		pq.push_back(10'h000);
		pq.push_back(10'h3FF);
		pq.push_back(10'h3FF);
		for (int i = 0; i < 3 + m_dc; i++) begin
			x = fw(i == 0 ? m_did : i == 1 ? m_sdid : i == 2 ? {6'h00, m_dc} : m_udw[i - 3]);
			s = s + x[8:0];
			pq.push_back(x);
		end
		pq.push_back(m_csm ? fw(m_cs) : {~s[8], s});
		pkts++;
	endtask
	always @(posedge clk) begin
		rd_d <= reg_rd;
		ins_d <= ins;
		li_d <= li;
		ci_d <= ci;
	end
	always @(negedge clk) begin
		if (live) begin
			if (rd_d) begin
				e = rq.size() > 0 ? rq.pop_front() : 32'hFFFFXXXX;
				check(reg_rdata, e[15:0], e[31:16]);
			end
			if (ins_d) begin
				w = pq.size() > 0 ? pq.pop_front() : 10'hXXX;
				check({6'h00, m_chr ? co : lo}, {6'h00, w}, 16'h03FF);
				check({6'h00, m_chr ? lo : co}, {6'h00, m_chr ? li_d : ci_d}, 16'h03FF);
			end else begin
				check({6'h00, lo}, {6'h00, li_d}, 16'h03FF);
				check({6'h00, co}, {6'h00, ci_d}, 16'h03FF);
			end
		end
	end
	initial begin
		{rst_b, live, reg_wr, reg_rd, reg_addr, reg_wdata, failures, total_checks, pkts} = '0;
		{m_par, m_csm, m_chr, m_cs, m_did, m_sdid, m_dc} = {3'h0, 10'h0, 10'h041, 10'h005, 4'h8};
		for (int i = 0; i < 8; i++) m_udw[i] = 10'h000;
		void'($urandom(32'h4dae4f26));
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		live = 1'b1;
		for (int i = 0; i < 16; i++) rd(4'(i), i < 8 ? rv[i] : 16'h0, 16'hFFFF);
		wait_frame();
		wr(4'h8, 16'h004C);
		wr(4'h0, 16'h0001);
		exp_pkt();
		exp_pkt();
		wait_frame();
		wait_frame();
		wr(4'h0, 16'h0000);
		wait_frame();
		rd(4'h7, 16'h0200, 16'hFF03);
		b1 = 16'($urandom);
		b2 = 16'($urandom);
		wr(4'hB, {8'h0, 4'($urandom_range(15)), 4'h0});
		wr(4'hC, {8'h0, b1[15:8]});
		wr(4'hD, {8'h0, b1[7:0]});
		wr(4'hE, {8'h0, b2[15:8]});
		wr(4'hF, {8'h0, b2[7:0]});
		wr(4'h5, 16'h000B);
		wr(4'h6, 16'h0019);
		wr(4'h0, 16'h0002);
		exp_pkt();
		wait_frame();
		wait_frame();
		rd(4'h0, 16'h0000, 16'h0003);
		wr(4'h3, 16'h0009);
		rd(4'h3, 16'h0008, 16'hFFFF);
		wr(4'h3, 16'h0003);
		for (int i = 8; i < 11; i++) wr(4'(i), 16'($urandom_range(1023)));
		wr(4'h4, 16'($urandom_range(1023)));
		wr(4'h0, 16'h000E);
		exp_pkt();
		wait_frame();
		wr(4'h0, 16'h0012);
		exp_pkt();
		wait_frame();
		wr(4'h0, 16'h000A);
		exp_pkt();
		wait_frame();
		wr(4'h3, 16'h0008);
		wr(4'h6, 16'h001A);
		wr(4'h0, 16'h0001);
		wait_frame();
		wait_frame();
		rd(4'h7, {8'(pkts), 8'h02}, 16'hFF03);
		wr(4'h0, 16'h0000);
		wait_frame();
		check(16'(pq.size() + rq.size()), 16'h0000, 16'hFFFF);
		end_of_test();
	end
endmodule // afd_anc_packet_inserter_tb
`default_nettype wire

//--- afd_inserter.sv
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "afd_regs.svh"
// Overview of operation
// - Packet carries identifier 0x41, secondary identifier 0x05, count of 8 words.
// - First user word holds aspect flag (1 = 16:9) beside four-bit format code.
// - Fourth user word: top, bottom, left, right bar flags high, low nibble zero.
// - Two sixteen-bit bar values in words five to eight, upper byte first.
// - User words are eight-bit; automatic parity appends parity bits by default.
// - Continuous output mode repeats insertion into the active stream.
// - Auto parity sends eight data bits; manual sends all ten stored bits.
// - Checksum either computed automatically or taken from a manual value.
// - Line or sample offset out of range blocks insertion.
// - Word count states user words sent, exactly that many before checksum.
module afd_inserter
	import afd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Video timing and format limits
	input wire logic [10:0] line_num,
	input wire logic [11:0] sample_num,
	input wire logic in_vertical_ancillary_space,
	input wire logic [10:0] vertical_ancillary_space_first_line,
	input wire logic [10:0] vertical_ancillary_space_last_line,
	input wire logic [11:0] active_width,
	// Video stream
	input wire logic [9:0] luma_in,
	input wire logic [9:0] chroma_in,
	output logic [9:0] luma_out,
	output logic [9:0] chroma_out,
	output logic inserting
);
	afd_word_if wp ();

	afd_mode_type mode, next_mode;
	logic par_man, next_par_man;
	logic cs_man, next_cs_man;
	logic chroma_sel, next_chroma_sel;
	logic [9:0] did, next_did;
	logic [9:0] sdid, next_sdid;
	logic [3:0] dc, next_dc;
	logic [9:0] cs_val, next_cs_val;
	logic [10:0] line_sel, next_line_sel;
	logic [11:0] offset, next_offset;
	logic [9:0] udw [0:7];
	logic [9:0] next_udw [0:7];
	logic [15:0] next_rdata;
	logic range_err, next_range_err;
	logic [7:0] pkt_count, next_pkt_count;

	afd_state_type state, next_state;
	logic [2:0] pos, next_pos;
	logic [2:0] uidx, next_uidx;
	logic [9:0] cur_word;
	logic [9:0] next_luma, next_chroma;
	logic range_ok;
	logic start;
	logic ctrl_wr;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] idx, input logic s);
		hit = s && (a == idx);
	endfunction

	assign ctrl_wr = hit(reg_addr, `AFD_REG_CTRL, reg_wr);

	always_comb begin
		// One bit of headroom so a large offset cannot wrap past the width check
		range_ok = (line_sel >= vertical_ancillary_space_first_line) && (line_sel <= vertical_ancillary_space_last_line)
			&& (({1'b0, offset} + {1'b0, `AFD_HDR_LEN} + {9'h000, dc}) <= {1'b0, active_width});
		start = (state == AFD_IDLE) && (mode != AFD_OUT_DISABLE) && range_ok
			&& in_vertical_ancillary_space && (line_num == line_sel) && (sample_num == offset);
	end

	// Register writes and readback
	always_comb begin
		next_mode = mode;
		next_par_man = par_man;
		next_cs_man = cs_man;
		next_chroma_sel = chroma_sel;
		next_did = did;
		next_sdid = sdid;
		next_dc = dc;
		next_cs_val = cs_val;
		next_line_sel = line_sel;
		next_offset = offset;
		next_udw = udw;
		next_rdata = 16'h0000;
		if (state == AFD_SUM && mode == AFD_OUT_SINGLE) begin
			next_mode = AFD_OUT_DISABLE;
		end
		if (ctrl_wr) begin
			next_mode = afd_mode_type'(reg_wdata[`AFD_CTRL_MODE_HI:`AFD_CTRL_MODE_LO]);
			next_par_man = reg_wdata[`AFD_CTRL_PAR_MAN];
			next_cs_man = reg_wdata[`AFD_CTRL_CS_MAN];
			next_chroma_sel = reg_wdata[`AFD_CTRL_CHROMA];
		end
		if (hit(reg_addr, `AFD_REG_DID, reg_wr)) begin
			next_did = reg_wdata[9:0];
		end
		if (hit(reg_addr, `AFD_REG_SDID, reg_wr)) begin
			next_sdid = reg_wdata[9:0];
		end
		if (hit(reg_addr, `AFD_REG_DC, reg_wr)) begin
			next_dc = (reg_wdata > 16'h0008) ? `AFD_UDW_MAX : reg_wdata[3:0];
		end
		if (hit(reg_addr, `AFD_REG_CS, reg_wr)) begin
			next_cs_val = reg_wdata[9:0];
		end
		if (hit(reg_addr, `AFD_REG_LINE, reg_wr)) begin
			next_line_sel = reg_wdata[10:0];
		end
		if (hit(reg_addr, `AFD_REG_OFFSET, reg_wr)) begin
			next_offset = reg_wdata[11:0];
		end
		if (reg_wr && reg_addr[3]) begin
			next_udw[reg_addr[2:0]] = reg_wdata[9:0];
		end
		if (reg_rd) begin
			case (reg_addr)
				`AFD_REG_CTRL: next_rdata = {11'h000, chroma_sel, cs_man, par_man, mode};
				`AFD_REG_DID: next_rdata = {6'h00, did};
				`AFD_REG_SDID: next_rdata = {6'h00, sdid};
				`AFD_REG_DC: next_rdata = {12'h000, dc};
				`AFD_REG_CS: next_rdata = {6'h00, cs_val};
				`AFD_REG_LINE: next_rdata = {5'h00, line_sel};
				`AFD_REG_OFFSET: next_rdata = {4'h0, offset};
				`AFD_REG_STATUS: next_rdata = {pkt_count, 6'h00, range_err, (state != AFD_IDLE)};
				default: next_rdata = {6'h00, udw[reg_addr[2:0]]};
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode <= AFD_OUT_DISABLE;
			par_man <= 1'b0;
			cs_man <= 1'b0;
			chroma_sel <= 1'b0;
			did <= `AFD_DID_RST;
			sdid <= `AFD_SDID_RST;
			dc <= `AFD_DC_RST;
			cs_val <= 10'h000;
			line_sel <= `AFD_LINE_RST;
			offset <= `AFD_OFFSET_RST;
			reg_rdata <= 16'h0000;
			for (int i = 0; i < 8; i++) begin
				udw[i] <= 10'h000;
			end
		end else begin
			mode <= next_mode;
			par_man <= next_par_man;
			cs_man <= next_cs_man;
			chroma_sel <= next_chroma_sel;
			did <= next_did;
			sdid <= next_sdid;
			dc <= next_dc;
			cs_val <= next_cs_val;
			line_sel <= next_line_sel;
			offset <= next_offset;
			reg_rdata <= next_rdata;
			udw <= next_udw;
		end
	end

	// Packet sequencer
	always_comb begin
		next_state = state;
		next_pos = pos;
		next_uidx = uidx;
		next_range_err = range_err;
		next_pkt_count = pkt_count;
		wp.raw = 10'h000;
		wp.clr = 1'b0;
		wp.add = 1'b0;
		wp.auto_par = !par_man;
		cur_word = wp.word;
		case (state)
			AFD_IDLE: begin
				wp.clr = 1'b1;
				// Flag holds the last verdict only at the placement point
				if (in_vertical_ancillary_space && line_num == line_sel && sample_num == offset) begin
					next_range_err = !range_ok;
				end
				// Header lands on the offset sample itself, not one later
				if (start) begin
					wp.raw = `AFD_ADF0;
					cur_word = wp.raw;
					next_state = AFD_HEAD;
					next_pos = 3'h1;
				end
			end
			AFD_HEAD: begin
				case (pos)
					3'h0: wp.raw = `AFD_ADF0;
					3'h3: wp.raw = did;
					3'h4: wp.raw = sdid;
					3'h5: wp.raw = {6'h00, dc};
					default: wp.raw = `AFD_ADF1;
				endcase
				// Flag words bypass parity formatting
				if (pos < `AFD_POS_DID) begin
					cur_word = wp.raw;
				end else begin
					wp.add = 1'b1;
				end
				next_pos = pos + 3'h1;
				if (pos == `AFD_POS_DC) begin
					next_uidx = 3'h0;
					next_state = (dc == 4'h0) ? AFD_SUM : AFD_USER;
				end
			end
			AFD_USER: begin
				wp.raw = udw[uidx];
				wp.add = 1'b1;
				next_uidx = uidx + 3'h1;
				if ({1'b0, uidx} == dc - 4'h1) begin
					next_state = AFD_SUM;
				end
			end
			AFD_SUM: begin
				if (cs_man) begin
					wp.raw = cs_val;
				end else begin
					wp.raw = {~wp.sum[8], wp.sum};
					wp.auto_par = 1'b0;
				end
				next_pkt_count = pkt_count + 8'h01;
				next_state = AFD_IDLE;
			end
			default: next_state = AFD_IDLE;
		endcase
	end

	always_comb begin
		inserting = (state != AFD_IDLE) || start;
		next_luma = (inserting && !chroma_sel) ? cur_word : luma_in;
		next_chroma = (inserting && chroma_sel) ? cur_word : chroma_in;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= AFD_IDLE;
			pos <= 3'h0;
			uidx <= 3'h0;
			range_err <= 1'b0;
			pkt_count <= 8'h00;
			luma_out <= 10'h000;
			chroma_out <= 10'h000;
		end else begin
			state <= next_state;
			pos <= next_pos;
			uidx <= next_uidx;
			range_err <= next_range_err;
			pkt_count <= next_pkt_count;
			luma_out <= next_luma;
			chroma_out <= next_chroma;
		end
	end

	afd_word_fmt u_fmt (
		.clk(clk),
		.rst_b(rst_b),
		.wp(wp.fmt)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_did_word: assert property ((state == AFD_HEAD && pos == 3'h3 && did == 10'h041 && !par_man) |-> cur_word == 10'h241)
		else $error("identifier word wrong");
	a_luma_insert: assert property ((inserting && !chroma_sel) |=> luma_out == $past(cur_word))
		else $error("inserted luma word wrong");
	a_manual_raw: assert property ((state == AFD_USER && par_man) |-> cur_word == udw[uidx])
		else $error("manual word altered");
	a_user_order: assert property ((state == AFD_USER) |-> cur_word[7:0] == udw[uidx][7:0])
		else $error("user word out of order");
	a_user_count: assert property ((state == AFD_HEAD && pos == 3'h5 && dc == 4'h8) |=> (state == AFD_USER) [*8] ##1 state == AFD_SUM)
		else $error("user word count wrong");
	a_range_block: assert property ((state == AFD_IDLE && !range_ok) |=> state == AFD_IDLE)
		else $error("insert out of range");
	a_sum_auto: assert property ((state == AFD_SUM && !cs_man) |-> cur_word == {~wp.sum[8], wp.sum})
		else $error("auto checksum wrong");
	a_single_once: assert property ((state == AFD_SUM && mode == AFD_OUT_SINGLE && !ctrl_wr) |=> mode == AFD_OUT_DISABLE)
		else $error("single packet mode not cleared");
	a_parity_word: assert property ((state == AFD_USER && !par_man) |-> cur_word[8] == ^udw[uidx][7:0])
		else $error("user parity wrong");

	c_continuous: cover property (state == AFD_SUM && mode == AFD_OUT_CONTINUOUS);
	c_single: cover property (state == AFD_SUM && mode == AFD_OUT_SINGLE);
	c_range_err: cover property (range_err);
	c_manual_cs: cover property (state == AFD_SUM && cs_man);
endmodule // afd_inserter
`default_nettype wire

//--- afd_pkg.sv
package afd_pkg;
	typedef enum logic [1:0] {
		AFD_OUT_DISABLE,
		AFD_OUT_CONTINUOUS,
		AFD_OUT_SINGLE,
		AFD_OUT_SPARE
	} afd_mode_type;
	typedef enum {
		AFD_IDLE,
		AFD_HEAD,
		AFD_USER,
		AFD_SUM
	} afd_state_type;
endpackage

//--- afd_regs.svh
`ifndef AFD_REGS_SVH
`define AFD_REGS_SVH
// Register indices on the plain register port
`define AFD_REG_CTRL 4'h0
`define AFD_REG_DID 4'h1
`define AFD_REG_SDID 4'h2
`define AFD_REG_DC 4'h3
`define AFD_REG_CS 4'h4
`define AFD_REG_LINE 4'h5
`define AFD_REG_OFFSET 4'h6
`define AFD_REG_STATUS 4'h7
`define AFD_REG_UDW0 4'h8
// Control field positions
`define AFD_CTRL_MODE_LO 0
`define AFD_CTRL_MODE_HI 1
`define AFD_CTRL_PAR_MAN 2
`define AFD_CTRL_CS_MAN 3
`define AFD_CTRL_CHROMA 4
// Reset values
`define AFD_DID_RST 10'h041
`define AFD_SDID_RST 10'h005
`define AFD_DC_RST 4'h8
`define AFD_LINE_RST 11'h009
`define AFD_OFFSET_RST 12'h000
// Packet layout
`define AFD_UDW_MAX 4'h8
`define AFD_ADF0 10'h000
`define AFD_ADF1 10'h3FF
`define AFD_POS_DID 3'h3
`define AFD_POS_DC 3'h5
`define AFD_HDR_LEN 12'h007
`endif

//--- afd_video_src.sv
`timescale 1ns/100ps
`default_nettype none
module afd_video_src #(
	parameter int W = 40,
	parameter int LINES = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Raster timing and limits
	output logic [10:0] line_num,
	output logic [11:0] sample_num,
	output logic vertical_ancillary_space,
	output logic [10:0] first_line,
	output logic [10:0] last_line,
	output logic [11:0] width,
	// Picture words
	output logic [9:0] luma,
	output logic [9:0] chroma
);
	assign first_line = 11'h002;
	assign last_line = 11'h00B;
	assign width = 12'(W);
	assign vertical_ancillary_space = (line_num >= first_line) && (line_num <= last_line);
	// Words change every sample so a stuck output cannot pass
	assign luma = {line_num[4:0], sample_num[4:0]};
	assign chroma = ~luma;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			line_num <= 11'h001;
			sample_num <= 12'h000;
		end else if (sample_num == 12'(W - 1)) begin
			sample_num <= 12'h000;
			line_num <= (line_num == 11'(LINES)) ? 11'h001 : line_num + 11'h001;
		end else begin
			sample_num <= sample_num + 12'h001;
		end
	end
endmodule // afd_video_src
`default_nettype wire

//--- afd_word_fmt.sv
`timescale 1ns/100ps
`default_nettype none
module afd_word_fmt
	import afd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Word path
	afd_word_if.fmt wp
);
	logic [8:0] sum;
	logic [8:0] next_sum;
	logic par;

	always_comb begin
		par = ^wp.raw[7:0];
		if (wp.auto_par) begin
			wp.word = {~par, par, wp.raw[7:0]};
		end else begin
			wp.word = wp.raw;
		end
	end

	always_comb begin
		next_sum = sum;
		if (wp.clr) begin
			next_sum = 9'h000;
		end else if (wp.add) begin
			next_sum = sum + wp.word[8:0];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sum <= 9'h000;
		end else begin
			sum <= next_sum;
		end
	end

	assign wp.sum = sum;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_parity_form: assert property (wp.auto_par |-> (wp.word[8] == ^wp.word[7:0]) && (wp.word[9] != wp.word[8]))
		else $error("auto parity word malformed");
	a_sum_clear: assert property (wp.clr |=> sum == 9'h000)
		else $error("checksum not cleared");
endmodule // afd_word_fmt
`default_nettype wire

//--- afd_word_if.sv
`timescale 1ns/100ps
`default_nettype none
interface afd_word_if;
	logic [9:0] raw;
	logic auto_par;
	logic clr;
	logic add;
	logic [9:0] word;
	logic [8:0] sum;
	modport fmt (input raw, input auto_par, input clr, input add, output word, output sum);
	modport user (output raw, output auto_par, output clr, output add, input word, input sum);
endinterface
`default_nettype wire
